/* logic/mlds_top.sv */
// Motor lock detection, drive method selection and output gating
// Overview of operation
// - Lock cycle: drive then six-times stop
// - Drive count starts above start threshold
// - Forward at 1 Hz or less is lock
// - Reverse at 5 Hz or less is lock
// - All drive off during stop
// - Command at disable resets counter, leaves stop
// - Drive 500, stop 3000 timer periods
// - No bootstrap refresh during stop
// - Open timer pin forces stop, drive off
// - Grounded timer pin disables lock detection
// - High-side supply fall blocks high side
// - Overtemp holds outputs off until recovery
// - Reverse or slow forward uses square wave
// - Fast forward: style picks wide or sine
// - Lead angle zero when slow or reverse
`timescale 1ns/1ps
module mlds_top
   import mlds_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic              i_resetn,
   input  wire logic              i_ce,
   input  wire logic              i_cmd_above_start,
   input  wire logic              i_cmd_above_disable,
   input  wire logic              i_rotation_dir_select,
   input  wire logic              i_style_wide,
   input  wire logic              i_lock_timer_osc,
   input  wire logic              i_lock_timer_cap_pin_open,
   input  wire logic              i_lock_timer_cap_pin_gnd,
   input  wire logic              i_high_side_supply_low,
   input  wire logic              i_overtemp_shutdown,
   input  wire logic              i_overtemp_recovered,
   input  wire logic [PER_W-1:0]  i_hall_period,
   input  wire logic              i_hall_reverse,
   output logic                   o_drive_enable,
   output logic                   o_high_side_enable,
   output logic                   o_refresh_allow,
   output logic                   o_lead_angle_zero,
   output mlds_mode_t             o_drive_mode,
   output logic                   o_lock_stop,
   output logic                   o_lock_drive
);
   import mlds_pkg::*;

   // ------------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------------
   localparam int unsigned NS = 10;
   logic [NS-1:0] raw_w, syn_w;
   assign raw_w = {i_cmd_above_start, i_cmd_above_disable, i_rotation_dir_select,
                   i_style_wide, i_lock_timer_osc, i_lock_timer_cap_pin_open,
                   i_lock_timer_cap_pin_gnd, i_high_side_supply_low,
                   i_overtemp_shutdown, i_overtemp_recovered};

   mlds_sync #(.W(NS)) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .i_ce      (i_ce),
      .i_async   (raw_w),
      .o_sync    (syn_w)
   );

   logic cmd_start_w, cmd_en_w, style_w, osc_w, tr_open_w, tr_gnd_w;
   logic hs_low_w, ot_w, ot_rec_w;
   assign cmd_start_w = syn_w[9];
   assign cmd_en_w    = syn_w[8];
   assign style_w     = syn_w[6];
   assign osc_w       = syn_w[5];
   assign tr_open_w   = syn_w[4];
   assign tr_gnd_w    = syn_w[3];
   assign hs_low_w    = syn_w[2];
   assign ot_w        = syn_w[1];
   assign ot_rec_w    = syn_w[0];

   logic tick_w;
   mlds_timer_tick u_tick (
      .i_ref_clk  (i_ref_clk),
      .i_resetn   (i_resetn),
      .i_ce       (i_ce),
      .i_osc_sync (osc_w),
      .o_tick     (tick_w)
   );

   // ------------------------------------------------------------------
   // Hall speed classification
   // ------------------------------------------------------------------
   // Hall period and reverse flag come from same-clock logic, no sync
   function automatic logic slow_at(input logic [PER_W-1:0] per,
                                    input logic [PER_W-1:0] lim);
      return per >= lim;
   endfunction

   logic fwd_slow_w, rev_slow_w, locked_cond_w;
   assign fwd_slow_w    = slow_at(i_hall_period, FWD_LIM_CYC);
   assign rev_slow_w    = slow_at(i_hall_period, REV_LIM_CYC);
   assign locked_cond_w = i_hall_reverse ? rev_slow_w : fwd_slow_w;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      mlds_lock_t       lock;
      logic [CNT_W-1:0] cnt;
      logic             ot_latch;
      logic             drive_en;
      logic             hs_en;
      logic             refresh;
      logic             la_zero;
      mlds_mode_t       mode;
      logic             stop;
      logic             ldrive;
   } mlds_state_t;
   mlds_state_t st_q, st_d;

   localparam logic [CNT_W-1:0] DRV_LAST = CNT_W'(DRIVE_COUNTS - 1);
   localparam logic [CNT_W-1:0] STP_LAST = CNT_W'(STOP_COUNTS - 1);

   always_comb begin
      logic stop_now;
      logic off_all;
      stop_now = 1'b0;
      off_all  = 1'b0;
      st_d = st_q;
      if (i_ce) begin
         // Lock cycle sequencer
         // Disable wins over everything: a dropped command must always restart clean
         // A grounded timer pin never oscillates, so the count could never finish
         if (!cmd_en_w) begin
            st_d.lock = MLDS_IDLE;
            st_d.cnt  = '0;
         end else if (tr_gnd_w) begin
            st_d.lock = MLDS_IDLE;
            st_d.cnt  = '0;
         end else begin
            unique case (st_q.lock)
               MLDS_IDLE: begin
                  if (cmd_start_w && locked_cond_w) begin
                     st_d.lock = MLDS_DRIVE;
                     st_d.cnt  = '0;
                  end
               end
               MLDS_DRIVE: begin
                  if (!cmd_start_w || !locked_cond_w) begin
                     st_d.lock = MLDS_IDLE;
                     st_d.cnt  = '0;
                  end else if (tick_w) begin
                     if (st_q.cnt == DRV_LAST) begin
                        st_d.lock = MLDS_STOP;
                        st_d.cnt  = '0;
                     end else begin
                        st_d.cnt = st_q.cnt + 1'b1;
                     end
                  end
               end
               MLDS_STOP: begin
                  // Stop is only left by the count, a command drop or a grounded timer pin
                  if (tick_w) begin
                     if (st_q.cnt == STP_LAST) begin
                        st_d.lock = MLDS_DRIVE;
                        st_d.cnt  = '0;
                     end else begin
                        st_d.cnt = st_q.cnt + 1'b1;
                     end
                  end
               end
               default: begin
                  st_d.lock = MLDS_IDLE;
                  st_d.cnt  = '0;
               end
            endcase
         end

         // Overtemp latch clears only at the hysteresis recovery point
         if (ot_w) begin
            st_d.ot_latch = 1'b1;
         end else if (ot_rec_w) begin
            st_d.ot_latch = 1'b0;
         end

         stop_now = (st_d.lock == MLDS_STOP) || (tr_open_w && !tr_gnd_w);
         off_all  = stop_now || st_d.ot_latch || ot_w || !cmd_en_w;

         st_d.drive_en = !off_all;
         st_d.hs_en    = !off_all && !hs_low_w;
         st_d.refresh  = cmd_en_w && !stop_now && !st_d.ot_latch;
         st_d.stop     = stop_now;
         st_d.ldrive   = (st_d.lock == MLDS_DRIVE);

         // Drive method selection
         // Uses the raw hall inputs: they are already on this clock
         if (i_hall_reverse || fwd_slow_w) begin
            st_d.mode = MLDS_SQUARE_120;
         end else if (style_w) begin
            st_d.mode = MLDS_WIDE_150;
         end else begin
            st_d.mode = MLDS_SINE_180;
         end
         st_d.la_zero = i_hall_reverse || fwd_slow_w;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= '{lock: MLDS_IDLE, mode: MLDS_SQUARE_120, la_zero: 1'b1, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   assign o_drive_enable     = st_q.drive_en;
   assign o_high_side_enable = st_q.hs_en;
   assign o_refresh_allow    = st_q.refresh;
   assign o_lead_angle_zero  = st_q.la_zero;
   assign o_drive_mode       = st_q.mode;
   assign o_lock_stop        = st_q.stop;
   assign o_lock_drive       = st_q.ldrive;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   stop_drive_off_a: assert property (o_lock_stop |-> !o_drive_enable)
      else $error("Drive enabled during lock stop");
   stop_no_refresh_a: assert property (o_lock_stop |-> !o_refresh_allow)
      else $error("Refresh allowed during lock stop");
   hs_low_off_a: assert property (i_ce && hs_low_w |=> !o_high_side_enable)
      else $error("High side enabled with supply low");
   ot_hold_a: assert property (st_q.ot_latch |-> !o_drive_enable)
      else $error("Outputs on while overtemp latched");
   cmd_low_reset_a: assert property (i_ce && !cmd_en_w |=> st_q.lock == MLDS_IDLE && !o_lock_stop)
      else $error("Lock not reset at disable");
   gnd_no_lock_a: assert property (i_ce && tr_gnd_w |=> st_q.lock == MLDS_IDLE)
      else $error("Lock active with timer pin grounded");
   open_stop_a: assert property (i_ce && tr_open_w && !tr_gnd_w |=> o_lock_stop)
      else $error("Open timer pin did not stop");
   drive_to_stop_a: assert property (i_ce && cmd_en_w && !tr_gnd_w && st_q.lock == MLDS_DRIVE
      && tick_w && st_q.cnt == DRV_LAST |=> st_q.lock == MLDS_STOP)
      else $error("Drive interval length wrong");
   square_slow_a: assert property (i_ce && (i_hall_reverse || fwd_slow_w)
      |=> o_drive_mode == MLDS_SQUARE_120 && o_lead_angle_zero)
      else $error("Square drive not chosen");
   fast_style_a: assert property (i_ce && !i_hall_reverse && !fwd_slow_w
      |=> o_drive_mode == ($past(style_w) ? MLDS_WIDE_150 : MLDS_SINE_180))
      else $error("Style selection wrong");
   below_start_a: assert property (i_ce && st_q.lock == MLDS_IDLE && !cmd_start_w
      |=> st_q.lock == MLDS_IDLE)
      else $error("Lock started below start threshold");


   // ------------------------------------------------------------------
   // Sequencer and gating checks
   // ------------------------------------------------------------------
   // The stop interval must run its full count, a missed tick only stretches it
   stop_to_drive_a: assert property (i_ce && cmd_en_w && !tr_gnd_w && st_q.lock == MLDS_STOP
      && tick_w && st_q.cnt == STP_LAST |=> st_q.lock == MLDS_DRIVE)
      else $error("Stop interval length wrong");
   stop_holds_a: assert property (i_ce && cmd_en_w && !tr_gnd_w && st_q.lock == MLDS_STOP
      && !tick_w |=> st_q.lock == MLDS_STOP)
      else $error("Stop left early");
   lock_entry_a: assert property (i_ce && cmd_en_w && !tr_gnd_w && st_q.lock == MLDS_IDLE
      && cmd_start_w && locked_cond_w |=> st_q.lock == MLDS_DRIVE)
      else $error("Lock not entered");
   lead_fast_a: assert property (i_ce && !i_hall_reverse && !fwd_slow_w
      |=> !o_lead_angle_zero)
      else $error("Lead angle held zero while fast");
   ot_off_a: assert property (i_ce && ot_w |=> !o_drive_enable)
      else $error("Outputs on during overtemp");
   ot_keep_a: assert property (i_ce && st_q.ot_latch && !ot_rec_w
      |=> st_q.ot_latch)
      else $error("Overtemp latch cleared early");
   disable_off_a: assert property (i_ce && !cmd_en_w
      |=> !o_drive_enable && !o_refresh_allow)
      else $error("Outputs on below disable");
   hs_follow_a: assert property (!o_drive_enable |-> !o_high_side_enable)
      else $error("High side on with drive off");
   cnt_bound_a: assert property (st_q.cnt <= STP_LAST)
      else $error("Lock counter out of range");
   // Clock enable low must freeze every bit, sequencer and outputs alike
   freeze_a: assert property (!i_ce |=> $stable(st_q))
      else $error("State moved with enable low");

   lock_drive_c: cover property (st_q.lock == MLDS_IDLE ##1 st_q.lock == MLDS_DRIVE);
   enter_stop_c: cover property (st_q.lock == MLDS_DRIVE ##1 st_q.lock == MLDS_STOP);
   stop_exit_c: cover property (st_q.lock == MLDS_STOP ##1 st_q.lock == MLDS_DRIVE);
   wide_mode_c: cover property (o_drive_mode == MLDS_WIDE_150);
   ot_recover_c: cover property (st_q.ot_latch ##1 !st_q.ot_latch);
endmodule // mlds_top

/* include/mlds_pkg.sv */
// Shared constants and types of the motor lock and drive select block
package mlds_pkg;
   // ------------------------------------------------------------------
   // Lock timer counts
   // ------------------------------------------------------------------
   localparam int unsigned DRIVE_COUNTS = 500;
   localparam int unsigned STOP_COUNTS  = 3000;
   localparam int unsigned STOP_RATIO   = 6;
   localparam int unsigned CNT_W        = 12;

   // ------------------------------------------------------------------
   // Hall frequency limits, in reference clock cycles of one hall period
   // ------------------------------------------------------------------
   localparam int unsigned CLK_HZ      = 200_000_000;
   localparam int unsigned FWD_LIM_HZ  = 1;
   localparam int unsigned REV_LIM_HZ  = 5;
   localparam int unsigned PER_W       = 32;
   localparam logic [PER_W-1:0] FWD_LIM_CYC = PER_W'(CLK_HZ / FWD_LIM_HZ);
   localparam logic [PER_W-1:0] REV_LIM_CYC = PER_W'(CLK_HZ / REV_LIM_HZ);

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {MLDS_SQUARE_120, MLDS_WIDE_150, MLDS_SINE_180} mlds_mode_t;
   typedef enum logic [1:0] {MLDS_IDLE, MLDS_DRIVE, MLDS_STOP} mlds_lock_t;
endpackage

/* logic/mlds_sync.sv */
// Two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module mlds_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_ce,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mlds_sync_t;
   mlds_sync_t st_q, st_d;

   always_comb begin
      st_d = st_q;
      if (i_ce) begin
         st_d.s1 = i_async;
         st_d.s2 = st_q.s1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_sync = st_q.s2;
endmodule // mlds_sync

/* logic/mlds_timer_tick.sv */
// Edge detector that turns the lock timer oscillator level into one-cycle ticks
`timescale 1ns/1ps
module mlds_timer_tick (
   input  wire logic i_ref_clk,
   input  wire logic i_resetn,
   input  wire logic i_ce,
   input  wire logic i_osc_sync,
   output logic      o_tick
);
   typedef struct packed {
      logic prev;
      logic tick;
   } mlds_tick_t;
   mlds_tick_t st_q, st_d;

   // One tick per full oscillator period: rising edges only
   always_comb begin
      st_d = st_q;
      if (i_ce) begin
         st_d.prev = i_osc_sync;
         st_d.tick = i_osc_sync & ~st_q.prev;
      end else begin
         st_d.tick = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_tick = st_q.tick;
endmodule // mlds_timer_tick

/* dv/mlds_far_model.sv */
// Far side model: lock timer oscillator that counts its own rising edges
`timescale 1ns/1ps
module mlds_far_model (
   input  wire logic i_ref_clk,
   input  wire logic i_run,
   output logic      o_osc,
   output int        o_rises
);
   // Four clocks a period; it stands still while not running
   logic div_q = 1'b0;
   initial begin
      o_osc = 1'b0;
      o_rises = 0;
   end
   always @(posedge i_ref_clk) begin
      if (i_run) begin
         div_q <= ~div_q;
         if (div_q) begin
            o_osc <= ~o_osc;
            if (!o_osc) o_rises <= o_rises + 1;
         end
      end
   end
endmodule // mlds_far_model

/* dv/test_motor_lock_and_drive_select.sv */
// Self-checking bench for the motor lock and drive select block
`timescale 1ns/1ps
module test_motor_lock_and_drive_select;
   import mlds_pkg::*;
   logic        ref_clk = 1'b0;
   logic        resetn  = 1'b0;
   logic        start   = 1'b0;
   logic        enable  = 1'b0;
   logic        dir     = 1'b0;
   logic        wide    = 1'b0;
   logic        osc_run = 1'b0;
   logic        pin_open = 1'b0;
   logic        pin_gnd = 1'b1;
   logic        hs_low  = 1'b0;
   logic        hot     = 1'b0;
   logic        cool    = 1'b0;
   logic        rev     = 1'b0;
   logic        ce      = 1'b1;
   logic [31:0] per     = 32'h0000_03e8;
   logic [31:0] pers [5] = '{32'h0000_03e8, REV_LIM_CYC - 1, REV_LIM_CYC, FWD_LIM_CYC - 1,
                             FWD_LIM_CYC};
   logic        osc, drv, hs, refr, lz, stp, ldr;
   mlds_mode_t  mode;
   int          rises, a, b, d, n;
   int          seed = 76778;
   int          error_cnt = 0;
   int          total_checks = 0;

   always #2.5 ref_clk = ~ref_clk;

   mlds_far_model u_far (.i_ref_clk(ref_clk), .i_run(osc_run), .o_osc(osc), .o_rises(rises));
   mlds_top u_dut (.i_ref_clk(ref_clk), .i_resetn(resetn), .i_ce(ce),
      .i_cmd_above_start(start), .i_cmd_above_disable(enable), .i_rotation_dir_select(dir),
      .i_style_wide(wide), .i_lock_timer_osc(osc), .i_lock_timer_cap_pin_open(pin_open),
      .i_lock_timer_cap_pin_gnd(pin_gnd), .i_high_side_supply_low(hs_low),
      .i_overtemp_shutdown(hot), .i_overtemp_recovered(cool), .i_hall_period(per),
      .i_hall_reverse(rev), .o_drive_enable(drv), .o_high_side_enable(hs),
      .o_refresh_allow(refr), .o_lead_angle_zero(lz), .o_drive_mode(mode),
      .o_lock_stop(stp), .o_lock_drive(ldr));

   // ---------------------------------------------------------------
   // Reference model and helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] exp_mode(input logic r, input logic [31:0] p,
                                             input logic w);
      if (r || p >= FWD_LIM_CYC) return 32'h0000_0000;
      return w ? 32'h0000_0001 : 32'h0000_0002;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
      end
   endtask

   // Three edges of sync and register latency, with margin
   task automatic settle;
      repeat (6) @(negedge ref_clk);
   endtask

   task automatic wait_for(input logic want_stop, output int cnt);
      for (n = 0; n < 20000 && (want_stop ? stp : ldr) !== 1'b1; n++)
         @(negedge ref_clk);
      chk(32'(n < 20000), 32'h0000_0001, "lock phase reached");
      cnt = rises;
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #300_000;
      error_cnt++;
      wrap_up();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(negedge ref_clk);
      resetn = 1'b1;
      chk(32'(drv), 32'h0000_0000, "reset drive");
      chk(32'(lz), 32'h0000_0001, "reset lead angle");
      chk(32'(mode), 32'h0000_0000, "reset mode");
      enable = 1'b1;
      start = 1'b1;
      for (int i = 0; i < 24; i++) begin
         {rev, wide, dir, hs_low} = 4'($random(seed));
         per = pers[{$random(seed)} % 5];
         settle();
         chk(32'(mode), exp_mode(rev, per, wide), "mode");
         chk(32'(lz), 32'(rev || per >= FWD_LIM_CYC), "lead angle zero");
         chk(32'(drv), 32'h0000_0001, "drive with grounded pin");
         chk(32'(ldr | stp), 32'h0000_0000, "no lock with grounded pin");
         chk(32'(hs), 32'(!hs_low), "high side gate");
      end
      hs_low = 1'b0;
      hot = 1'b1;
      settle();
      chk(32'(drv), 32'h0000_0000, "overtemp off");
      hot = 1'b0;
      settle();
      chk(32'(drv), 32'h0000_0000, "overtemp held");
      cool = 1'b1;
      settle();
      chk(32'(drv), 32'h0000_0001, "overtemp recovered");
      cool = 1'b0;
      // Enable low: an overtemp pulse inside the freeze must never be seen
      ce = 1'b0;
      hot = 1'b1;
      settle();
      chk(32'(drv), 32'h0000_0001, "frozen by enable");
      hot = 1'b0;
      ce = 1'b1;
      settle();
      chk(32'(drv), 32'h0000_0001, "enable resumed");
      // Refresh band: above disable, at or below start
      pin_gnd = 1'b0;
      osc_run = 1'b1;
      rev = 1'b0;
      per = FWD_LIM_CYC;
      start = 1'b0;
      settle();
      chk(32'(refr), 32'h0000_0001, "refresh in band");
      chk(32'(ldr | stp), 32'h0000_0000, "lock idle in band");
      enable = 1'b0;
      settle();
      chk(32'(drv), 32'h0000_0000, "off below disable");
      enable = 1'b1;
      start = 1'b1;
      per = FWD_LIM_CYC - 1;
      settle();
      chk(32'(ldr), 32'h0000_0000, "forward just fast");
      rev = 1'b1;
      per = REV_LIM_CYC - 1;
      settle();
      chk(32'(ldr), 32'h0000_0000, "reverse just fast");
      per = REV_LIM_CYC;
      settle();
      chk(32'(ldr), 32'h0000_0001, "reverse slow locks");
      // Clean lock cycle from the initial state
      enable = 1'b0;
      rev = 1'b0;
      per = FWD_LIM_CYC;
      settle();
      enable = 1'b1;
      wait_for(1'b0, a);
      chk(32'(mode), 32'h0000_0000, "square while locked");
      wait_for(1'b1, b);
      chk(32'((b - a) inside {[498:502]}), 32'h0000_0001, "drive length");
      chk(32'({drv, hs, refr}), 32'h0000_0000, "stop outputs off");
      wait_for(1'b0, d);
      chk(32'((d - b) inside {[2998:3002]}), 32'h0000_0001, "stop length");
      chk(32'(((d - b) + 250) / (b - a)), 32'h0000_0006, "stop to drive ratio");
      wait_for(1'b1, b);
      enable = 1'b0;
      settle();
      chk(32'({stp, drv}), 32'h0000_0000, "disable leaves stop");
      enable = 1'b1;
      settle();
      chk(32'({ldr, stp}), 32'h0000_0002, "restart from drive");
      pin_open = 1'b1;
      settle();
      chk(32'({stp, drv}), 32'h0000_0002, "open pin stops");
      wrap_up();
   end
endmodule // test_motor_lock_and_drive_select
